// ---- wdt_top.sv ----
// Guard timer with AXI4-Lite access to its single register
// Overview of operation
// - Active counter expiring without reload requests a system reset.
// - Each software write of a count reloads the down-counter.
// - Software option: inactive, no reset, stop allowed until activation bit written one.
// - Once active, clearing the activation bit is ignored until device reset.
// - Hardware option: activation bit reads one and ignores writes.
// - Hardware option: stop executes as wait; counting continues.
// - After leaving stop, an active counter resumes where it stopped.
// - Reset loads the register with 0xfe: longest period, inactive.
// - Self-reset bit falling from one to zero while active requests a reset.
// - Period bits are reversed: register bit 7 is counter LSB.
// - Only period bits set the timeout; software keeps self-reset bit one.
// - Timeout selectable in 64 steps, 3072 to 196608 clock cycles.
// - While inactive, a free 7-bit down-timer; reaching zero causes no reset.
// - Counter clocked from the internal clock divided by twelve.
// - At least 28 instructions run after activation before any reset.
// - Watchdog reset restarts the device like an external reset.
`timescale 1ns/1ns
module wdt_top
    import wdt_pkg::*;
#(
    parameter bit HW_ACTIVATION = 1'b0
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // AXI4-Lite write address
    input wire logic [AXI_ADDR_W-1:0] AWADDR,
    input wire logic [2:0] AWPROT,
    input wire logic AWVALID,
    output logic AWREADY,
    // AXI4-Lite write data
    input wire logic [AXI_DATA_W-1:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    // AXI4-Lite write response
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // AXI4-Lite read address
    input wire logic [AXI_ADDR_W-1:0] ARADDR,
    input wire logic [2:0] ARPROT,
    input wire logic ARVALID,
    output logic ARREADY,
    // AXI4-Lite read data
    output logic [AXI_DATA_W-1:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // Core power mode
    input wire logic STOP_MODE,
    output logic STOP_AS_WAIT,
    output logic STOP_ALLOWED,
    // Status and reset request to the reset generator
    output logic WDG_ACTIVE,
    output logic WDG_RESET
);

    // Register bit i maps to counter bit (7 - i) for the period and self-reset bits
    function automatic logic [CNT_W-1:0] reg_to_cnt(input logic [7:0] value);
        logic [CNT_W-1:0] result;
        result = '0;
        for (int i = 0; i < CNT_W; i++) begin
            result[i] = value[PERIOD_LSB_BIT - i];
        end
        return result;
    endfunction

    function automatic logic [7:0] cnt_to_reg(input wdt_state_s st);
        logic [7:0] result;
        result = '0;
        result[ACTIVATE_BIT] = st.active;
        for (int i = 0; i < CNT_W; i++) begin
            result[PERIOD_LSB_BIT - i] = st.cnt[i];
        end
        return result;
    endfunction

    // Under the hardware option the state itself is active from reset, so expiry resets too
    localparam wdt_state_s STATE_RESET = '{
        active: GUARD_REGISTER_RESET[ACTIVATE_BIT] || HW_ACTIVATION,
        cnt: reg_to_cnt(GUARD_REGISTER_RESET)
    };

    // Write channel capture
    logic aw_held;
    logic w_held;
    logic [AXI_ADDR_W-1:0] wr_addr;
    logic [7:0] wr_data;
    logic wr_strb;
    wdt_wreq_s wreq;
    logic do_write;
    logic wr_hit;
    logic [1:0] bresp;
    logic bvalid;

    // Read channel
    logic [AXI_DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rd_take;

    // Watchdog core
    wdt_state_s state;
    wdt_state_s next_state;
    logic reset_req;
    logic wdg_reset;
    logic count_en;
    logic tick_div;
    logic tick_step;
    logic reload;
    logic div_restart;

    // Ready outputs are combinational; only one write and one read in flight
    assign AWREADY = !aw_held && !bvalid;
    assign WREADY = !w_held && !bvalid;
    assign ARREADY = !rvalid;
    assign BRESP = bresp;
    assign BVALID = bvalid;
    assign RDATA = rdata;
    assign RRESP = rresp;
    assign RVALID = rvalid;

    // Each capture field has its own register so no variable has two writers
    assign wreq = '{addr: wr_addr, data: wr_data, strb: wr_strb};
    assign do_write = aw_held && w_held && !bvalid;
    assign wr_hit = (wreq.addr[AXI_ADDR_W-1:2] == GUARD_REGISTER_ADDR[AXI_ADDR_W-1:2]);
    assign reload = do_write && wr_hit && wreq.strb;
    assign rd_take = ARVALID && !rvalid;

    // Address and data may arrive in either order
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            aw_held <= 1'b0;
            wr_addr <= '0;
        end else if (AWVALID && AWREADY) begin
            aw_held <= 1'b1;
            wr_addr <= AWADDR;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            w_held <= 1'b0;
            wr_data <= '0;
            wr_strb <= 1'b0;
        end else if (WVALID && WREADY) begin
            w_held <= 1'b1;
            wr_data <= WDATA[7:0];
            wr_strb <= WSTRB[0];
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (BREADY) begin
            bvalid <= 1'b0;
        end
    end

    // Read returns the live count, so software can use it as a timer
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (rd_take) begin
            rvalid <= 1'b1;
            if (ARADDR[AXI_ADDR_W-1:2] == GUARD_REGISTER_ADDR[AXI_ADDR_W-1:2]) begin
                rdata <= {24'h000000, cnt_to_reg(state)};
                rresp <= RESP_OKAY;
            end else begin
                rdata <= '0;
                rresp <= RESP_SLVERR;
            end
        end else if (RREADY) begin
            rvalid <= 1'b0;
        end
    end

    // Stop freezes the count only where stop really halts the oscillator
    assign count_en = !(STOP_MODE && !HW_ACTIVATION);

    // A reload restarts both stages, so every period is a whole number of steps
    // A watchdog reset restarts them as a pin reset would
    assign div_restart = reload || wdg_reset;
    wdt_div #(
        .DIV(CLK_DIV)
    ) u_div12 (
        .clk(MCLK),
        .rst_n(RESETN),
        .restart(div_restart),
        .en(count_en),
        .tick(tick_div)
    );

    wdt_div #(
        .DIV(PRESCALE)
    ) u_prescale (
        .clk(MCLK),
        .rst_n(RESETN),
        .restart(div_restart),
        .en(tick_div),
        .tick(tick_step)
    );

    // Next state and reset request
    always_comb begin
        next_state = state;
        reset_req = 1'b0;
        if (reload) begin
            next_state.cnt = reg_to_cnt(wreq.data);
            if (HW_ACTIVATION) begin
                next_state.active = 1'b1;
            end else begin
                next_state.active = state.active || wreq.data[ACTIVATE_BIT];
            end
            // Clearing the self-reset bit by software is an immediate reset
            if (next_state.active && state.cnt[CNT_W-1] && !next_state.cnt[CNT_W-1]) begin
                reset_req = 1'b1;
            end
        end else if (tick_step) begin
            next_state.cnt = state.cnt - 1'b1;
            // Self-reset bit falls when the period bits run out
            if (state.active && state.cnt == CNT_SR_ONLY) begin
                reset_req = 1'b1;
            end
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            state <= STATE_RESET;
        end else if (wdg_reset) begin
            state <= STATE_RESET;
        end else begin
            state <= next_state;
        end
    end

    // One-cycle request; the external generator adds the stabilisation delay
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            wdg_reset <= 1'b0;
        end else begin
            wdg_reset <= reset_req && !wdg_reset;
        end
    end

    assign WDG_RESET = wdg_reset;
    assign WDG_ACTIVE = state.active || HW_ACTIVATION;
    assign STOP_AS_WAIT = HW_ACTIVATION;
    assign STOP_ALLOWED = !HW_ACTIVATION && !state.active;

endmodule

// ---- wdt_pkg.sv ----
// Constants, field positions and carrier types of the guard timer
package wdt_pkg;

    // Register bus
    localparam int unsigned AXI_ADDR_W = 8;
    localparam int unsigned AXI_DATA_W = 32;
    localparam logic [AXI_ADDR_W-1:0] GUARD_REGISTER_ADDR = 8'hd8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Guard register layout
    localparam int unsigned ACTIVATE_BIT = 0;
    localparam int unsigned SELF_RESET_BIT = 1;
    localparam int unsigned PERIOD_MSB_BIT = 2;
    localparam int unsigned PERIOD_LSB_BIT = 7;
    localparam logic [7:0] GUARD_REGISTER_RESET = 8'hfe;

    // Down-counter: six period bits plus the self-reset bit on top
    localparam int unsigned CNT_W = 7;
    localparam logic [CNT_W-1:0] CNT_SR_ONLY = 7'h40;

    // Timing: internal clock divided by twelve, then a prescaler of 256
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned CLK_DIV = 12;
    localparam int unsigned PRESCALE = 256;
    localparam int unsigned STEP_CYCLES = CLK_DIV * PRESCALE;
    localparam int unsigned MIN_TIMEOUT_CYCLES = 3072;
    localparam int unsigned MAX_TIMEOUT_CYCLES = 196608;
    localparam int unsigned PERIOD_STEPS = 64;
    localparam int unsigned MIN_ARM_INSTR = 28;

    // Live watchdog state
    typedef struct packed {
        logic active;
        logic [CNT_W-1:0] cnt;
    } wdt_state_s;

    // Captured write request
    typedef struct packed {
        logic [AXI_ADDR_W-1:0] addr;
        logic [7:0] data;
        logic strb;
    } wdt_wreq_s;

endpackage

// ---- wdt_div.sv ----
// Restartable clock-enable divider used for the divide-by-twelve and the prescaler
`timescale 1ns/1ns
module wdt_div
    import wdt_pkg::*;
#(
    parameter int unsigned DIV = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic restart,
    input wire logic en,
    // Output enable pulse
    output logic tick
);

    localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] cnt;

    assign tick = en && (cnt == LAST);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
        end else if (restart) begin
            cnt <= '0;
        end else if (en) begin
            if (cnt == LAST) begin
                cnt <= '0;
            end else begin
                cnt <= cnt + 1'b1;
            end
        end
    end

endmodule

// ---- wdt_props.sv ----
// Port-level properties of the guard timer
`timescale 1ns/1ns
module wdt_props
    import wdt_pkg::*;
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // Bus handshakes
    input wire logic AWVALID,
    input wire logic AWREADY,
    input wire logic WVALID,
    input wire logic WREADY,
    input wire logic BVALID,
    input wire logic BREADY,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic RVALID,
    input wire logic RREADY,
    // Watchdog status
    input wire logic STOP_AS_WAIT,
    input wire logic STOP_ALLOWED,
    input wire logic WDG_ACTIVE,
    input wire logic WDG_RESET
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    sequence wr_take;
        AWVALID && AWREADY && WVALID && WREADY;
    endsequence
    sequence rd_take;
        ARVALID && ARREADY;
    endsequence
    wr_answer_a: assert property (wr_take |-> ##2 BVALID)
        else $error("write answer not two cycles after take");
    b_hold_a: assert property (BVALID && !BREADY |=> BVALID)
        else $error("write answer dropped early");
    rd_answer_a: assert property (rd_take |=> RVALID)
        else $error("read answer late");
    r_hold_a: assert property (RVALID && !RREADY |=> RVALID)
        else $error("read answer dropped early");
    pulse_one_a: assert property (WDG_RESET |=> !WDG_RESET)
        else $error("reset request longer than one cycle");
    pulse_active_a: assert property (WDG_RESET |-> WDG_ACTIVE)
        else $error("reset request while inactive");
    active_keep_a: assert property (WDG_ACTIVE && !WDG_RESET |=> WDG_ACTIVE)
        else $error("watchdog left active state");
    reset_clear_a: assert property (WDG_RESET && !STOP_AS_WAIT |-> ##[1:2] !WDG_ACTIVE)
        else $error("reset request did not restore inactive state");
    stop_gate_a: assert property (STOP_ALLOWED == (!STOP_AS_WAIT && !WDG_ACTIVE))
        else $error("stop availability wrong");
endmodule

bind wdt_top wdt_props u_props (.MCLK(MCLK), .RESETN(RESETN), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY),
    .STOP_AS_WAIT(STOP_AS_WAIT), .STOP_ALLOWED(STOP_ALLOWED), .WDG_ACTIVE(WDG_ACTIVE),
    .WDG_RESET(WDG_RESET));

// ---- tb_digital_watchdog_timer.sv ----
// Self-checking bench for the guard timer
`timescale 1ns/1ns
module tb_digital_watchdog_timer
    import wdt_pkg::*;
();
    logic MCLK = 1'h0;
    logic RESETN = 1'h0;
    logic [7:0] AWADDR = 8'h0, ARADDR = 8'h0;
    logic [31:0] WDATA = 32'h0, RDATA;
    logic AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0;
    logic STOP_MODE = 1'h0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, STOP_AS_WAIT, STOP_ALLOWED;
    logic WDG_ACTIVE, WDG_RESET;
    logic HW_ACTIVE, HW_STOP_WAIT, HW_STOP_OK;
    logic [1:0] BRESP, RRESP;
    int errors = 0, samples_checked = 0, cyc = 0, pulses = 0, last_pulse = 0, t, p0;
    localparam logic [7:0] A = GUARD_REGISTER_ADDR;

    wdt_top u_dut (.MCLK(MCLK), .RESETN(RESETN), .AWADDR(AWADDR), .AWPROT(3'h0),
        .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'h1), .WVALID(WVALID),
        .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
        .ARPROT(3'h0), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
        .RVALID(RVALID), .RREADY(RREADY), .STOP_MODE(STOP_MODE), .STOP_AS_WAIT(STOP_AS_WAIT),
        .STOP_ALLOWED(STOP_ALLOWED), .WDG_ACTIVE(WDG_ACTIVE), .WDG_RESET(WDG_RESET));

    // Hardware option copy with an idle bus: its longest period outlasts the run
    wdt_top #(.HW_ACTIVATION(1'b1)) u_dut_hw (.MCLK(MCLK), .RESETN(RESETN), .AWADDR(8'h0),
        .AWPROT(3'h0), .AWVALID(1'h0), .AWREADY(), .WDATA(32'h0), .WSTRB(4'h0),
        .WVALID(1'h0), .WREADY(), .BRESP(), .BVALID(), .BREADY(1'h0), .ARADDR(8'h0),
        .ARPROT(3'h0), .ARVALID(1'h0), .ARREADY(), .RDATA(), .RRESP(), .RVALID(),
        .RREADY(1'h0), .STOP_MODE(1'h1), .STOP_AS_WAIT(HW_STOP_WAIT),
        .STOP_ALLOWED(HW_STOP_OK), .WDG_ACTIVE(HW_ACTIVE), .WDG_RESET());

    always #5 MCLK = ~MCLK;
    // Pulse log kept apart so a missed one-cycle request is still seen
    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        if (WDG_RESET === 1'h1) begin
            pulses <= pulses + 1;
            last_pulse <= cyc;
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            errors++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        @(posedge MCLK);
        AWADDR <= a;
        WDATA <= {24'h0, d};
        AWVALID <= 1'h1;
        WVALID <= 1'h1;
        BREADY <= 1'h1;
        n = 0;
        do begin
            @(posedge MCLK);
            n++;
            if (AWREADY) AWVALID <= 1'h0;
            if (WREADY) WVALID <= 1'h0;
        end while (BVALID !== 1'h1 && n < 50);
        BREADY <= 1'h0;
        chk("bvalid", 1'h1, BVALID);
        chk("bresp", er, BRESP);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
        int n;
        @(posedge MCLK);
        ARADDR <= a;
        ARVALID <= 1'h1;
        RREADY <= 1'h1;
        n = 0;
        do begin
            @(posedge MCLK);
            n++;
            if (ARREADY) ARVALID <= 1'h0;
        end while (RVALID !== 1'h1 && n < 50);
        RREADY <= 1'h0;
        chk("rvalid", 1'h1, RVALID);
        chk("rdata", {24'h0, ed}, RDATA);
        chk("rresp", er, RRESP);
    endtask

    task automatic t_reset;
        rd(A, GUARD_REGISTER_RESET, RESP_OKAY);
        chk("active", 1'h0, WDG_ACTIVE);
        chk("stop_ok", 1'h1, STOP_ALLOWED);
        chk("stop_wait", 1'h0, STOP_AS_WAIT);
        chk("hw_active", 1'h1, HW_ACTIVE);
        chk("hw_stop_wait", 1'h1, HW_STOP_WAIT);
        chk("hw_stop_ok", 1'h0, HW_STOP_OK);
        wr(8'hdc, 8'h03, RESP_SLVERR);
        rd(8'h00, 8'h00, RESP_SLVERR);
        chk("active", 1'h0, WDG_ACTIVE);
        $display("t_reset done");
    endtask

    // Inactive timer: count steps, freeze in stop, no reset at the bottom
    task automatic t_timer;
        p0 = pulses;
        wr(A, 8'h02, RESP_OKAY);
        repeat (STEP_CYCLES + 20) @(posedge MCLK);
        rd(A, 8'hfc, RESP_OKAY);
        wr(A, 8'hfe, RESP_OKAY);
        STOP_MODE <= 1'h1;
        repeat (4000) @(posedge MCLK);
        STOP_MODE <= 1'h0;
        rd(A, 8'hfe, RESP_OKAY);
        repeat (STEP_CYCLES) @(posedge MCLK);
        rd(A, 8'h7e, RESP_OKAY);
        wr(A, 8'h00, RESP_OKAY);
        repeat (4) @(posedge MCLK);
        chk("no_reset", p0, pulses);
        $display("t_timer done");
    endtask

    task automatic t_expire;
        p0 = pulses;
        wr(A, 8'h83, RESP_OKAY);
        chk("stop_ok", 1'h0, STOP_ALLOWED);
        repeat (3) begin
            repeat (4000) @(posedge MCLK);
            wr(A, 8'h82, RESP_OKAY);
        end
        t = cyc;
        rd(A, 8'h83, RESP_OKAY);
        chk("reloaded", p0, pulses);
        repeat (6300) @(posedge MCLK);
        chk("expired", p0 + 1, pulses);
        chk("expiry_win", 1'h1, last_pulse - t > 6135 && last_pulse - t < 6155);
        rd(A, GUARD_REGISTER_RESET, RESP_OKAY);
        $display("t_expire done");
    endtask

    task automatic t_selfreset;
        p0 = pulses;
        wr(A, 8'h03, RESP_OKAY);
        repeat (4) @(posedge MCLK);
        chk("no_reset", p0, pulses);
        rd(A, 8'h03, RESP_OKAY);
        wr(A, 8'h01, RESP_OKAY);
        repeat (4) @(posedge MCLK);
        chk("sr_reset", p0 + 1, pulses);
        chk("active", 1'h0, WDG_ACTIVE);
        $display("t_selfreset done");
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Tests need about 30000 cycles; twice that means a hang
    initial begin
        repeat (60000) @(posedge MCLK);
        errors++;
        wrap_up();
    end

    initial begin
        repeat (6) @(posedge MCLK);
        RESETN <= 1'h1;
        t_reset();
        t_timer();
        t_expire();
        t_selfreset();
        wrap_up();
    end
endmodule
